// ---- hw/fsac_defs.svh ----
`ifndef FSAC_DEFS_SVH
`define FSAC_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses inside the control space)
// ----------------------------------------------------------------------
`define FSAC_ADDR_W 12
`define FSAC_HFS_OFF 12'hd2c
`define FSAC_MMFA_OFF 12'hd34
`define FSAC_BFA_OFF 12'hd38
`define FSAC_IST_OFF 12'hd40
`define FSAC_IMSK_OFF 12'hd44

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FSAC_HFS_FORCED_BIT 30
`define FSAC_HFS_VECT_BIT 1
`define FSAC_EV_FORCED 0
`define FSAC_EV_VECT 1
`define FSAC_EV_MM 2
`define FSAC_EV_BUS 3
`define FSAC_EV_N 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FSAC_HFS_RESET 1'b0
`define FSAC_ADDR_RESET 32'h0000_0000
`define FSAC_IRQ_RESET 4'h0
`define FSAC_RD_IDLE 32'h0000_0000

`endif

// ---- hw/fsac_pkg.sv ----
`include "fsac_defs.svh"

package fsac_pkg;

   // ----------------------------------------------------------------------
   // register port request, one cycle per access
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [`FSAC_ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
      logic priv;
   } fsac_bus_s;

   // ----------------------------------------------------------------------
   // fault events reported by the core, one-cycle pulses
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic forcedEsc;
      logic vectFault;
      logic mmFault;
      logic [31:0] memmanage_fault_address;
      logic busFault;
      logic [31:0] busAddr;
   } fsac_evt_s;

   // top-level state
   typedef struct packed {
      logic hfForced;
      logic hfVect;
      logic [`FSAC_EV_N-1:0] irqStat;
      logic [`FSAC_EV_N-1:0] irqMask;
      logic [31:0] rdData;
   } fsac_state_s;

   // capture register state
   typedef struct packed {
      logic [31:0] addr;
   } fsac_cap_s;

   // reset synchroniser state
   typedef struct packed {
      logic [1:0] sync;
   } fsac_rst_s;

endpackage

// ---- hw/fsac_rst_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsac_defs.svh"

module fsac_rst_sync (
   input wire logic sys_clk,
   input wire logic nrst,
   output logic rstSyncN
);
   import fsac_pkg::*;

   fsac_rst_s st;
   fsac_rst_s next_st;

   // shift ones in after release; assert is immediate, release is clean
   always_comb begin
      next_st.sync = {st.sync[0], 1'b1};
   end

   // constant on reset only; free of the clock enable on purpose
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rstSyncN = st.sync[1];

endmodule
`default_nettype wire

// ---- hw/fsac_addr_capture.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsac_defs.svh"

module fsac_addr_capture (
   input wire logic sys_clk,
   input wire logic rstSyncN,
   input wire logic ce,
   input wire logic load,
   input wire logic [31:0] loadAddr,
   input wire logic swWr,
   input wire logic [31:0] swData,
   output logic [31:0] addr
);
   import fsac_pkg::*;

   fsac_cap_s st;
   fsac_cap_s next_st;

   // hardware capture beats a software write in the same cycle,
   // so a fault address is never lost to a racing store
   always_comb begin
      next_st = st;
      if (swWr) begin
         next_st.addr = swData;
      end
      if (load) begin
         next_st.addr = loadAddr;
      end
   end

   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         st.addr <= `FSAC_ADDR_RESET;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign addr = st.addr;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   a_capture_wins: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
      ce && load |=> addr == $past(loadAddr))
      else $error("capture lost to software write");

endmodule
`default_nettype wire

// ---- hw/fsac_fault_status.sv ----
// Summary of operation
// RULE1: escalated unhandled fault sets forced flag bit 30
// RULE2: vector table bus error sets bit 1
// RULE3: other hard status bits always read zero
// RULE4: flags clear only on written one
// RULE5: only privileged accesses reach the registers
// RULE6: memory fault captures actual faulting sub-access address
// RULE7: split access address may be any spanned byte
// RULE8: memory fault address trusted only with valid flag
// RULE9: bus fault captures address requested by instruction
// RULE10: bus fault address trusted only with valid flag
// RULE11: handler reads other status registers on forced fault
`timescale 1ns/10ps
`default_nettype none
`include "fsac_defs.svh"

module fsac_fault_status (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire fsac_pkg::fsac_bus_s busReq,
   output logic [31:0] rdData,
   input wire fsac_pkg::fsac_evt_s evt,
   input wire logic mmAddrValid,
   input wire logic busAddrValid,
   output logic [31:0] mmFaultAddr,
   output logic mmFaultAddrOk,
   output logic [31:0] busFaultAddr,
   output logic busFaultAddrOk,
   output logic forcedEscalation,
   output logic vectorReadFault,
   output logic irq
);
   import fsac_pkg::*;

   // ----------------------------------------------------------------------
   // decode helper
   // ----------------------------------------------------------------------

   // a privileged access to one offset; unprivileged ones never match
   function automatic logic regHit(
      input fsac_bus_s req,
      input logic [`FSAC_ADDR_W-1:0] off
   );
      return req.priv && (req.addr == off); // RULE5
   endfunction

   // ----------------------------------------------------------------------
   // reset and state
   // ----------------------------------------------------------------------
   logic rstSyncN;
   fsac_state_s st;
   fsac_state_s next_st;
   logic [`FSAC_EV_N-1:0] evVec;
   logic [`FSAC_EV_N-1:0] clrVec;
   logic wrHfs;
   logic wrIst;
   logic wrImsk;
   logic wrMmfa;
   logic wrBfa;
   logic [31:0] hfsWord;
   logic [31:0] istWord;
   logic [31:0] imskWord;

   fsac_rst_sync u_rst (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .rstSyncN(rstSyncN)
   );

   // ----------------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------------

   // writes from unprivileged code fall through without effect
   assign wrHfs = busReq.wr && regHit(busReq, `FSAC_HFS_OFF); // RULE5
   assign wrIst = busReq.wr && regHit(busReq, `FSAC_IST_OFF);
   assign wrImsk = busReq.wr && regHit(busReq, `FSAC_IMSK_OFF);
   assign wrMmfa = busReq.wr && regHit(busReq, `FSAC_MMFA_OFF);
   assign wrBfa = busReq.wr && regHit(busReq, `FSAC_BFA_OFF);

   // ----------------------------------------------------------------------
   // address capture registers
   // ----------------------------------------------------------------------

   // the core hands over the aligned sub-access that faulted, which
   // lies somewhere inside the requested span for split accesses
   fsac_addr_capture u_mm_cap (
      .sys_clk(sys_clk),
      .rstSyncN(rstSyncN),
      .ce(ce),
      .load(evt.mmFault), // RULE6 RULE7
      .loadAddr(evt.memmanage_fault_address), // RULE6 RULE7
      .swWr(wrMmfa),
      .swData(busReq.wdata),
      .addr(mmFaultAddr)
   );

   // bus faults keep the address the instruction asked for, even when
   // an unaligned access failed on a later piece
   fsac_addr_capture u_bus_cap (
      .sys_clk(sys_clk),
      .rstSyncN(rstSyncN),
      .ce(ce),
      .load(evt.busFault), // RULE9
      .loadAddr(evt.busAddr), // RULE9
      .swWr(wrBfa),
      .swData(busReq.wdata),
      .addr(busFaultAddr)
   );

   // qualifiers come from the fault status registers kept elsewhere
   assign mmFaultAddrOk = mmAddrValid; // RULE8
   assign busFaultAddrOk = busAddrValid; // RULE10

   // ----------------------------------------------------------------------
   // events and interrupt clears
   // ----------------------------------------------------------------------

   // event vector in the status register layout
   assign evVec[`FSAC_EV_FORCED] = evt.forcedEsc;
   assign evVec[`FSAC_EV_VECT] = evt.vectFault;
   assign evVec[`FSAC_EV_MM] = evt.mmFault;
   assign evVec[`FSAC_EV_BUS] = evt.busFault;

   // per-bit write-one-to-clear of the interrupt status
   genvar gi;
   generate
      for (gi = 0; gi < `FSAC_EV_N; gi++) begin : g_clr
         assign clrVec[gi] = wrIst && busReq.wdata[gi];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // read words
   // ----------------------------------------------------------------------

   // reserved positions tie to zero; debug bit is not kept here
   always_comb begin
      hfsWord = 32'h0000_0000; // RULE3
      hfsWord[`FSAC_HFS_FORCED_BIT] = st.hfForced;
      hfsWord[`FSAC_HFS_VECT_BIT] = st.hfVect;
      istWord = 32'h0000_0000;
      istWord[`FSAC_EV_N-1:0] = st.irqStat;
      imskWord = 32'h0000_0000;
      imskWord[`FSAC_EV_N-1:0] = st.irqMask;
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------

   // in each flag the clear is applied first so that an event in the
   // same cycle still wins and is never dropped
   always_comb begin
      next_st = st;

      // forced escalation flag
      if (wrHfs && busReq.wdata[`FSAC_HFS_FORCED_BIT]) begin
         next_st.hfForced = 1'b0; // RULE4
      end
      if (evt.forcedEsc) begin
         next_st.hfForced = 1'b1; // RULE1
      end

      // vector-read fault flag
      if (wrHfs && busReq.wdata[`FSAC_HFS_VECT_BIT]) begin
         next_st.hfVect = 1'b0; // RULE4
      end
      if (evt.vectFault) begin
         next_st.hfVect = 1'b1; // RULE2
      end

      // interrupt status: sticky, write one clears, set wins
      next_st.irqStat = (st.irqStat & ~clrVec) | evVec;

      // mask is plain read/write
      if (wrImsk) begin
         next_st.irqMask = busReq.wdata[`FSAC_EV_N-1:0];
      end

      // read data stand only in the cycle after the strobe
      next_st.rdData = `FSAC_RD_IDLE;
      if (busReq.rd && busReq.priv) begin // RULE5
         case (busReq.addr)
            `FSAC_HFS_OFF: begin
               next_st.rdData = hfsWord; // RULE3
            end
            `FSAC_MMFA_OFF: begin
               next_st.rdData = mmFaultAddr;
            end
            `FSAC_BFA_OFF: begin
               next_st.rdData = busFaultAddr;
            end
            `FSAC_IST_OFF: begin
               next_st.rdData = istWord;
            end
            `FSAC_IMSK_OFF: begin
               next_st.rdData = imskWord;
            end
            default: begin
               next_st.rdData = `FSAC_RD_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------

   // clock enable low freezes everything, read data included
   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         st.hfForced <= `FSAC_HFS_RESET;
         st.hfVect <= `FSAC_HFS_RESET;
         st.irqStat <= `FSAC_IRQ_RESET;
         st.irqMask <= `FSAC_IRQ_RESET;
         st.rdData <= `FSAC_RD_IDLE;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign rdData = st.rdData;
   assign forcedEscalation = st.hfForced;
   assign vectorReadFault = st.hfVect;
   // level output, drops as soon as software clears or masks
   assign irq = |(st.irqStat & st.irqMask);

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstSyncN);

   sequence s_hfs_read;
      ce && busReq.rd && busReq.priv && busReq.addr == `FSAC_HFS_OFF;
   endsequence

   sequence s_forced_clear;
      ce && wrHfs && busReq.wdata[`FSAC_HFS_FORCED_BIT] && !evt.forcedEsc;
   endsequence

   a_forced_set: assert property ( // RULE1
      ce && evt.forcedEsc |=> forcedEscalation)
      else $error("forced flag not set by escalation");

   a_vect_set: assert property ( // RULE2
      ce && evt.vectFault |=> vectorReadFault)
      else $error("vector read flag not set");

   a_reserved_zero: assert property ( // RULE3
      s_hfs_read |=> rdData[29:2] == 28'h0 && !rdData[0] && !rdData[31])
      else $error("reserved hard fault bits not zero");

   a_hfs_readback: assert property ( // RULE1
      s_hfs_read ##0 (!evt.forcedEsc && !wrHfs) |=>
         rdData[`FSAC_HFS_FORCED_BIT] == $past(forcedEscalation))
      else $error("hard fault status read mismatch");

   a_w1c_clear: assert property ( // RULE4
      s_forced_clear |=> !forcedEscalation)
      else $error("write one did not clear forced flag");

   a_zero_write_keep: assert property ( // RULE4
      ce && wrHfs && !busReq.wdata[`FSAC_HFS_VECT_BIT] && !evt.vectFault
         |=> vectorReadFault == $past(vectorReadFault))
      else $error("write zero changed vector flag");

   a_unpriv_read: assert property ( // RULE5
      ce && busReq.rd && !busReq.priv |=> rdData == 32'h0)
      else $error("unprivileged read returned data");

   a_unpriv_write: assert property ( // RULE5
      ce && busReq.wr && !busReq.priv && !evt.mmFault
         |=> mmFaultAddr == $past(mmFaultAddr))
      else $error("unprivileged write reached address register");

   a_mm_capture: assert property ( // RULE6
      ce && evt.mmFault |=> mmFaultAddr == $past(evt.memmanage_fault_address))
      else $error("memory fault address not captured");

   a_bus_capture: assert property ( // RULE9
      ce && evt.busFault ##1 !ce [*2] |=> busFaultAddr == $past(evt.busAddr, 3))
      else $error("bus fault address not held while frozen");

   a_irq_follows: assert property (
      ce && evt.busFault && st.irqMask[`FSAC_EV_BUS] && !wrImsk |=> irq)
      else $error("unmasked event gave no interrupt");

   a_mm_valid: assert property ( // RULE8
      mmFaultAddrOk == mmAddrValid)
      else $error("memory address valid flag not passed on");

   a_bus_valid: assert property ( // RULE10
      busFaultAddrOk == busAddrValid)
      else $error("bus address valid flag not passed on");

   a_read_idle: assert property (
      ce && !busReq.rd |=> rdData == 32'h0)
      else $error("read data stood without a read strobe");

endmodule
`default_nettype wire

// ---- tb/fsac_fault_status_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsac_defs.svh"

module fsac_fault_status_tb;
   import fsac_pkg::*;

   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic sysClk = 1'b0;
   logic nrst;
   logic ce;
   fsac_bus_s busReq;
   fsac_evt_s evt;
   logic mmAddrValid;
   logic busAddrValid;
   logic [31:0] rdData;
   logic [31:0] mmFaultAddr;
   logic [31:0] busFaultAddr;
   logic mmFaultAddrOk;
   logic busFaultAddrOk;
   logic forcedEscalation;
   logic vectorReadFault;
   logic irq;
   int failures = 0;
   int numChecks = 0;
   int cycles = 0;
   logic [31:0] val;
   logic [31:0] a;
   logic [31:0] b;
   fsac_evt_s e;

   // clock at 250 MHz
   always #2 sysClk = ~sysClk;

   fsac_fault_status i_fsac_fault_status (
      .sys_clk(sysClk),
      .nrst(nrst),
      .ce(ce),
      .busReq(busReq),
      .rdData(rdData),
      .evt(evt),
      .mmAddrValid(mmAddrValid),
      .busAddrValid(busAddrValid),
      .mmFaultAddr(mmFaultAddr),
      .mmFaultAddrOk(mmFaultAddrOk),
      .busFaultAddr(busFaultAddr),
      .busFaultAddrOk(busFaultAddrOk),
      .forcedEscalation(forcedEscalation),
      .vectorReadFault(vectorReadFault),
      .irq(irq)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // expected hard fault word, every other bit reads zero
   function automatic logic [31:0] hfsWord(input logic f, input logic v);
      return {1'b0, f, 28'h0000000, v, 1'b0};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      numChecks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic testDone();
      $display("checks %0d mismatches %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // one-cycle write; the slave never stalls
   task automatic busWrite(input logic [11:0] ad, input logic [31:0] d,
                           input logic p);
      @(posedge sysClk);
      busReq.addr <= ad;
      busReq.wdata <= d;
      busReq.priv <= p;
      busReq.wr <= 1'b1;
      @(posedge sysClk);
      busReq.wr <= 1'b0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic busRead(input logic [11:0] ad, input logic p,
                          output logic [31:0] d);
      @(posedge sysClk);
      busReq.addr <= ad;
      busReq.priv <= p;
      busReq.rd <= 1'b1;
      @(posedge sysClk);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask

   task automatic pulse(input fsac_evt_s ev);
      @(posedge sysClk);
      evt <= ev;
      @(posedge sysClk);
      evt <= '0;
      #1;
   endtask

   // hang guard, generous against the roughly 130 cycles needed
   always @(posedge sysClk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         $display("mismatch at %0t: run did not finish", $time);
         testDone();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      busReq = '0;
      evt = '0;
      mmAddrValid = 1'b0;
      busAddrValid = 1'b0;
      void'($urandom(32'hbfbd7f3c));
      repeat (2) @(posedge sysClk);
      nrst <= 1'b1;
      repeat (2) @(posedge sysClk);

      // state out of reset
      chk(forcedEscalation, 1'b0, "forced at reset");
      chk(vectorReadFault, 1'b0, "vect at reset");
      chk(irq, 1'b0, "irq at reset");
      busRead(`FSAC_HFS_OFF, 1'b1, val);
      chk(val, 32'h0000_0000, "status at reset");
      $display("test reset done");

      // forced escalation set, zero writes and unprivileged clears ignored
      e = '0;
      e.forcedEsc = 1'b1;
      pulse(e);
      chk(forcedEscalation, 1'b1, "forced set");
      // a handler looks at the other status word for the cause
      busRead(`FSAC_IST_OFF, 1'b1, val);
      chk(val, 32'h0000_0001, "cause visible");
      busRead(`FSAC_HFS_OFF, 1'b1, val);
      chk(val, hfsWord(1'b1, 1'b0), "forced word");
      busWrite(`FSAC_HFS_OFF, 32'hbfff_fffd, 1'b1);
      busRead(`FSAC_HFS_OFF, 1'b1, val);
      chk(val, hfsWord(1'b1, 1'b0), "zero write kept flag");
      busWrite(`FSAC_HFS_OFF, 32'h4000_0000, 1'b0);
      chk(forcedEscalation, 1'b1, "unpriv clear");
      busWrite(`FSAC_HFS_OFF, 32'h4000_0000, 1'b1);
      chk(forcedEscalation, 1'b0, "forced clear");
      $display("test forced done");

      // vector read fault, set beats a clear in the same cycle
      e = '0;
      e.vectFault = 1'b1;
      pulse(e);
      busRead(`FSAC_HFS_OFF, 1'b1, val);
      chk(val, hfsWord(1'b0, 1'b1), "vect word");
      @(posedge sysClk);
      evt <= e;
      busReq.addr <= `FSAC_HFS_OFF;
      busReq.wdata <= 32'h0000_0002;
      busReq.wr <= 1'b1;
      @(posedge sysClk);
      evt <= '0;
      busReq.wr <= 1'b0;
      #1 chk(vectorReadFault, 1'b1, "set beats clear");
      busWrite(`FSAC_HFS_OFF, 32'h0000_0002, 1'b1);
      chk(vectorReadFault, 1'b0, "vect clear");
      // a frozen clock enable must swallow the event
      @(posedge sysClk);
      ce <= 1'b0;
      e = '0;
      e.forcedEsc = 1'b1;
      pulse(e);
      @(posedge sysClk);
      ce <= 1'b1;
      #1 chk(forcedEscalation, 1'b0, "event while frozen");
      $display("test vect done");

      // random captures of both fault addresses
      for (int i = 0; i < 8; i++) begin
         a = $urandom();
         b = $urandom();
         e = '0;
         e.mmFault = 1'b1;
         e.memmanage_fault_address = a;
         e.busFault = i[0];
         e.busAddr = b;
         pulse(e);
         chk(mmFaultAddr, a, "mm capture");
         busRead(`FSAC_MMFA_OFF, 1'b1, val);
         chk(val, a, "mm read");
         if (i[0]) begin
            busRead(`FSAC_BFA_OFF, 1'b1, val);
            chk(val, b, "bus read");
         end
         busRead(`FSAC_BFA_OFF, 1'b0, val);
         chk(val, 32'h0000_0000, "unpriv read");
         @(posedge sysClk);
         mmAddrValid <= 1'($urandom_range(1));
         busAddrValid <= 1'($urandom_range(1));
         #1 chk(mmFaultAddrOk, mmAddrValid, "mm valid");
         chk(busFaultAddrOk, busAddrValid, "bus valid");
      end
      chk(busFaultAddr, b, "bus capture");
      busWrite(`FSAC_MMFA_OFF, ~a, 1'b0);
      chk(mmFaultAddr, a, "unpriv write");
      busWrite(`FSAC_MMFA_OFF, ~a, 1'b1);
      busRead(`FSAC_MMFA_OFF, 1'b1, val);
      chk(val, ~a, "mm software write");
      busWrite(`FSAC_BFA_OFF, ~b, 1'b1);
      chk(busFaultAddr, ~b, "bus software write");
      // a capture just before a two-cycle freeze must survive it
      e = '0;
      e.busFault = 1'b1;
      e.busAddr = $urandom();
      @(posedge sysClk);
      evt <= e;
      @(posedge sysClk);
      evt <= '0;
      ce <= 1'b0;
      repeat (2) @(posedge sysClk);
      ce <= 1'b1;
      #1 chk(busFaultAddr, e.busAddr, "bus capture frozen");
      busWrite(12'hd30, 32'hffff_ffff, 1'b1);
      busRead(12'hd30, 1'b1, val);
      chk(val, 32'h0000_0000, "unmapped read");
      $display("test capture done");

      // interrupt status, mask and clear
      busRead(`FSAC_IST_OFF, 1'b1, val);
      chk(val, 32'h0000_000f, "irq status");
      chk(irq, 1'b0, "masked irq");
      busWrite(`FSAC_IMSK_OFF, 32'h0000_0004, 1'b1);
      chk(irq, 1'b1, "unmasked irq");
      busRead(`FSAC_IMSK_OFF, 1'b1, val);
      chk(val, 32'h0000_0004, "mask read");
      busWrite(`FSAC_IST_OFF, 32'h0000_0004, 1'b1);
      chk(irq, 1'b0, "irq cleared");
      busRead(`FSAC_IST_OFF, 1'b1, val);
      chk(val, 32'h0000_000b, "status after clear");
      // fresh bus event with its mask bit open raises the line
      busWrite(`FSAC_IST_OFF, 32'h0000_0008, 1'b1);
      busWrite(`FSAC_IMSK_OFF, 32'h0000_0008, 1'b1);
      chk(irq, 1'b0, "bus status cleared");
      e = '0;
      e.busFault = 1'b1;
      e.busAddr = a;
      pulse(e);
      chk(irq, 1'b1, "bus event irq");
      $display("test irq done");
      testDone();
   end
endmodule

`default_nettype wire
